/* logic/fwal_consts.vh */
// fwal_consts.vh: offsets, field positions, reset values and codes
// of the fault/warning alert block; definitions only
`ifndef FWAL_CONSTS_VH
`define FWAL_CONSTS_VH

// apb register byte offsets
`define FWAL_ADDR_CTRL        8'h00
`define FWAL_ADDR_STATUS      8'h04
`define FWAL_ADDR_MASK_FIRST  8'h08
`define FWAL_ADDR_MASK_SECOND 8'h0C
`define FWAL_ADDR_ALERT_MODE  8'h10
`define FWAL_ADDR_ALERT_STATE 8'h14
`define FWAL_ADDR_SAMPLE      8'h18

// control register fields
`define FWAL_CTRL_ON          0
`define FWAL_CTRL_CLEAR       1

// status bit positions
`define FWAL_ST_UV_FAULT      0
`define FWAL_ST_OV_FAULT      1
`define FWAL_ST_OC_FAULT      2
`define FWAL_ST_CML           3
`define FWAL_ST_REG_ACTIVE    4
`define FWAL_ST_IOUT_OC       5
`define FWAL_ST_IOUT_WARN2    6
`define FWAL_ST_VIN_UV        7
`define FWAL_ST_VIN_OV        8
`define FWAL_ST_VOUT_UV       9
`define FWAL_ST_VOUT_OV       10
`define FWAL_ST_FET_BAD       15
`define FWAL_FAULT_MASK       16'h0007

// alert mode register fields
`define FWAL_MODE_INV         0
`define FWAL_MODE_GPO         2
`define FWAL_MODE_LVL         4

// reset values
`define FWAL_RST_CTRL         2'h1
`define FWAL_RST_MASK_FIRST   16'h0000
`define FWAL_RST_MASK_SECOND  16'h8000
`define FWAL_RST_MODE         6'h00

// alert response address and the read byte that carries it
`define FWAL_ARA_ADDR         7'h0C
`define FWAL_ARA_BYTE         8'h19

// adc code encodings: zero sense voltage at mid-scale
`define FWAL_CODE_MIDSCALE    12'h800
// code steps in nanovolts: sense 12.4 uV, voltage 1.488 mV / 5.208 mV
`define FWAL_SENSE_STEP_NV    12400
`define FWAL_VSTEP_6V_NV      1488000
`define FWAL_VSTEP_20V_NV     5208000

`endif

/* logic/fwal_alert.v */
// fwal_alert.v: latched fault/warning status, two open-drain alert
// outputs, apb register slave and alert response address responder.
// assumes apb master on pclk; smbus pins and fault inputs are async.
//
// Overview of operation
// - uv, ov and overcurrent-timeout faults latch and turn hot-swap off.
// - the three fault sources are always monitored, no setting disables them.
// - a status bit reads 1 once set and stays latched.
// - a bit clears only if inactive, on clear-faults or output off-then-on.
// - nine warning sources set status but never touch the hot-swap output.
// - current codes are raw 12-bit, zero at 2048, 12.4 uV per step.
// - voltage codes are raw 12-bit, step 1.488 mV or 5.208 mV.
// - after power-up every alert output is released.
// - first output has no source enabled; second only fet-health-bad.
// - an enabled event drives its alert active, low unless inverted.
// - outputs assert independently; a release frees both unless one is newly set that cycle.
// - clear-faults releases alerts; persistent faults do not reassert them.
// - a violating monitor sample after clear-faults raises a fresh alert.
// - on alert response read at 0x0C return own 7-bit address.
// - arbitrate on address bits, lowest address wins and withdraws alert.
// - after sending its address the device releases alerts in acknowledge.
// - after an alert response status stays and alerts stay inactive.
// - only an enabled bit going 0 to 1 raises a new alert.
// - mask words select sources per output; gpo mode ignores the mask.
// - monitor warnings trigger only strictly above or below a threshold.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "fwal_consts.vh"

module fwal_alert (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        uv_event,
	input  wire        ov_event,
	input  wire        oc_timeout,
	input  wire        current_regulation_active_warn,
	input  wire        fet_health_bad,
	input  wire        cml_error,
	input  wire        sample_valid,
	input  wire [11:0] iout_code,
	input  wire [11:0] vin_code,
	input  wire [11:0] vout_code,
	input  wire [11:0] iout_oc_limit,
	input  wire [11:0] second_current_warn_limit,
	input  wire        second_warn_under,
	input  wire [11:0] vin_uv_limit,
	input  wire [11:0] vin_ov_limit,
	input  wire [11:0] vout_uv_limit,
	input  wire [11:0] vout_ov_limit,
	input  wire [6:0]  dev_addr,
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe_n,
	output reg         hs_gate_on,
	output reg         alert_out_first,
	output reg         alert_out_first_oe_n,
	output reg         alert_out_second,
	output reg         alert_out_second_oe_n
);

	localparam ST_IDLE = 5'b00001;
	localparam ST_ADDR = 5'b00010;
	localparam ST_ACK  = 5'b00100;
	localparam ST_SEND = 5'b01000;
	localparam ST_SPAR = 5'b10000;

	function above;
		input [11:0] value;
		input [11:0] limit;
		begin
			above = value > limit;
		end
	endfunction

	// async inputs: uv, ov, oc, regulation, fet, scl, sda, address strap
	reg  [13:0] sync1_q;
	reg  [13:0] sync2_q;
	reg         scl_d3_q;
	reg         sda_d3_q;
	wire        uv_s   = sync2_q[0];
	wire        ov_s   = sync2_q[1];
	wire        oc_s   = sync2_q[2];
	wire        reg_s  = sync2_q[3];
	wire        fet_s  = sync2_q[4];
	wire        scl_s  = sync2_q[5];
	wire        sda_s  = sync2_q[6];
	wire [6:0]  addr_s = sync2_q[13:7];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q  <= 14'h0060;
			sync2_q  <= 14'h0060;
			scl_d3_q <= 1'b1;
			sda_d3_q <= 1'b1;
		end else begin
			sync1_q  <= {dev_addr, sda_in, scl_in, fet_health_bad,
				current_regulation_active_warn, oc_timeout,
				ov_event, uv_event};
			sync2_q  <= sync1_q;
			scl_d3_q <= scl_s;
			sda_d3_q <= sda_s;
		end
	end

	reg  [1:0]  ctrl_q;
	reg         op_prev_q;
	reg  [15:0] status_q;
	reg  [15:0] mask_q [0:1];
	reg  [5:0]  mode_q;
	reg  [1:0]  pend_q;
	reg  [11:0] iout_last_q;
	reg  [11:0] vin_last_q;
	reg         ara_won_q;

	wire apb_wr = psel & penable & pready & pwrite;
	wire clr_cmd = apb_wr & (paddr == `FWAL_ADDR_CTRL) &
		pwdata[`FWAL_CTRL_CLEAR];
	wire op_reenable = ctrl_q[`FWAL_CTRL_ON] & ~op_prev_q;
	wire clear_any = clr_cmd | op_reenable;

	// monitor compares only on a fresh sample, strict both ways
	wire w2_hit = second_warn_under ?
		above(second_current_warn_limit, iout_code) :
		above(iout_code, second_current_warn_limit);

	reg  [15:0] cond;
	always @* begin
		cond = 16'h0000;
		cond[`FWAL_ST_UV_FAULT]   = uv_s;
		cond[`FWAL_ST_OV_FAULT]   = ov_s;
		cond[`FWAL_ST_OC_FAULT]   = oc_s;
		cond[`FWAL_ST_CML]        = cml_error;
		cond[`FWAL_ST_REG_ACTIVE] = reg_s;
		cond[`FWAL_ST_IOUT_OC]    = sample_valid &
			above(iout_code, iout_oc_limit);
		cond[`FWAL_ST_IOUT_WARN2] = sample_valid & w2_hit;
		cond[`FWAL_ST_VIN_UV]     = sample_valid &
			above(vin_uv_limit, vin_code);
		cond[`FWAL_ST_VIN_OV]     = sample_valid &
			above(vin_code, vin_ov_limit);
		cond[`FWAL_ST_VOUT_UV]    = sample_valid &
			above(vout_uv_limit, vout_code);
		cond[`FWAL_ST_VOUT_OV]    = sample_valid &
			above(vout_code, vout_ov_limit);
		cond[`FWAL_ST_FET_BAD]    = fet_s;
	end

	// an active condition wins over any clear in the same cycle
	wire [15:0] status_d = (status_q & ~({16{clear_any}} & ~cond)) |
		cond;
	// sample warnings are events, so after a clear the next bad sample
	// is a fresh 0->1 edge and alerts again
	wire [15:0] new_set = cond & ~status_q;
	wire        release_all = clear_any | ara_won_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q    <= 16'h0000;
			op_prev_q   <= 1'b1;
			iout_last_q <= `FWAL_CODE_MIDSCALE;
			vin_last_q  <= 12'h000;
		end else begin
			status_q  <= status_d;
			op_prev_q <= ctrl_q[`FWAL_CTRL_ON];
			if (sample_valid) begin
				iout_last_q <= iout_code;
				vin_last_q  <= vin_code;
			end
		end
	end

	// hot-swap output: warnings never enter this term
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hs_gate_on <= 1'b0;
		else
			hs_gate_on <= ctrl_q[`FWAL_CTRL_ON] &
				~|(status_d & `FWAL_FAULT_MASK);
	end

	wire [1:0] alert_trig;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_alert
			assign alert_trig[gi] = ~mode_q[`FWAL_MODE_GPO + gi] &
				|(new_set & mask_q[gi]);
		end
	endgenerate

	// one process owns both pending bits, set wins over release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pend_q <= 2'h0;
		else
			pend_q <= alert_trig |
				(pend_q & ~{2{release_all}});
	end

	wire act_first  = mode_q[`FWAL_MODE_GPO] ?
		mode_q[`FWAL_MODE_LVL] : pend_q[0];
	wire act_second = mode_q[`FWAL_MODE_GPO + 1] ?
		mode_q[`FWAL_MODE_LVL + 1] : pend_q[1];

	// open drain: inverted active level means released while active
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_out_first       <= 1'b0;
			alert_out_second      <= 1'b0;
			alert_out_first_oe_n  <= 1'b1;
			alert_out_second_oe_n <= 1'b1;
		end else begin
			alert_out_first       <= 1'b0;
			alert_out_second      <= 1'b0;
			alert_out_first_oe_n  <= ~(act_first ^
				mode_q[`FWAL_MODE_INV]);
			alert_out_second_oe_n <= ~(act_second ^
				mode_q[`FWAL_MODE_INV + 1]);
		end
	end

	// apb slave: one wait state, registered answer
	reg [31:0] rd_mux;
	reg        rd_err;
	always @* begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
		`FWAL_ADDR_CTRL:        rd_mux = {31'h0, ctrl_q[`FWAL_CTRL_ON]};
		`FWAL_ADDR_STATUS:      rd_mux = {16'h0, status_q};
		`FWAL_ADDR_MASK_FIRST:  rd_mux = {16'h0, mask_q[0]};
		`FWAL_ADDR_MASK_SECOND: rd_mux = {16'h0, mask_q[1]};
		`FWAL_ADDR_ALERT_MODE:  rd_mux = {26'h0, mode_q};
		`FWAL_ADDR_ALERT_STATE: rd_mux = {29'h0, hs_gate_on, pend_q};
		`FWAL_ADDR_SAMPLE:      rd_mux = {4'h0, vin_last_q,
			3'h0, (iout_last_q < `FWAL_CODE_MIDSCALE),
			iout_last_q};
		default:                rd_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & rd_err;
			prdata  <= (psel & penable & ~pready & ~pwrite) ?
				rd_mux : 32'h0000_0000;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= `FWAL_RST_CTRL;
			mask_q[0] <= `FWAL_RST_MASK_FIRST;
			mask_q[1] <= `FWAL_RST_MASK_SECOND;
			mode_q    <= `FWAL_RST_MODE;
		end else if (apb_wr) begin
			case (paddr)
			`FWAL_ADDR_CTRL:
				ctrl_q[`FWAL_CTRL_ON] <= pwdata[`FWAL_CTRL_ON];
			`FWAL_ADDR_MASK_FIRST:  mask_q[0] <= pwdata[15:0];
			`FWAL_ADDR_MASK_SECOND: mask_q[1] <= pwdata[15:0];
			`FWAL_ADDR_ALERT_MODE:  mode_q <= pwdata[5:0];
			default:                ctrl_q <= ctrl_q;
			endcase
		end
	end

	// alert response responder: only the 0x0C receive-byte is answered
	wire scl_rise = scl_s & ~scl_d3_q;
	wire scl_fall = ~scl_s & scl_d3_q;
	wire start_c  = scl_s & sda_d3_q & ~sda_s;
	wire stop_c   = scl_s & ~sda_d3_q & sda_s;

	reg  [4:0] st_q;
	reg  [3:0] cnt_q;
	reg  [7:0] sh_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= ST_IDLE;
			cnt_q     <= 4'h0;
			sh_q      <= 8'h00;
			sda_out   <= 1'b0;
			sda_oe_n  <= 1'b1;
			ara_won_q <= 1'b0;
		end else begin
			ara_won_q <= 1'b0;
			sda_out   <= 1'b0;
			if (start_c) begin
				st_q     <= ST_ADDR;
				cnt_q    <= 4'h0;
				sda_oe_n <= 1'b1;
			end else if (stop_c) begin
				st_q     <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else begin
				case (st_q)
				ST_ADDR: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (sh_q == `FWAL_ARA_BYTE && |pend_q) begin
							sda_oe_n <= 1'b0;
							st_q     <= ST_ACK;
						end else
							st_q <= ST_SPAR;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						sh_q     <= {addr_s, 1'b1};
						sda_oe_n <= addr_s[6];
						cnt_q    <= 4'h0;
						st_q     <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (scl_rise) begin
						if (sh_q[7] && !sda_s) begin
							sda_oe_n <= 1'b1;
							st_q     <= ST_SPAR;
						end else
							cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							sda_oe_n  <= 1'b1;
							ara_won_q <= 1'b1;
							st_q      <= ST_SPAR;
						end else begin
							sh_q     <= {sh_q[6:0], 1'b1};
							sda_oe_n <= sh_q[6];
						end
					end
				end
				ST_SPAR:
					sda_oe_n <= 1'b1;
				ST_IDLE:
					sda_oe_n <= 1'b1;
				default: begin
					st_q     <= ST_IDLE;
					sda_oe_n <= 1'b1;
				end
				endcase
			end
		end
	end

endmodule // fwal_alert

/* tb/fwal_alert_props.sv */
// fwal_alert_props.sv: port assertions for the alert block
// assumes one pclk domain; bound from tb
`timescale 1ns/1ns
module fwal_alert_props (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        pslverr,
	input wire        uv_event,
	input wire        ov_event,
	input wire        oc_timeout,
	input wire        sda_out,
	input wire        sda_oe_n,
	input wire        hs_gate_on,
	input wire        alert_out_first,
	input wire        alert_out_first_oe_n,
	input wire        alert_out_second,
	input wire        alert_out_second_oe_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] hold_q;
	wire        fault_in = uv_event | ov_event | oc_timeout;
	// gate may only fall shortly after a fault pin or a control write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_q <= 3'h0;
		else if (fault_in | (psel & pwrite & (paddr == 8'h00)))
			hold_q <= 3'h7;
		else if (hold_q != 3'h0)
			hold_q <= hold_q - 3'h1;
	end
	rst_release_a: assert property ($rose(presetn) |->
		alert_out_first_oe_n && alert_out_second_oe_n && sda_oe_n)
		else $error("pin driven after reset");
	od_low_a: assert property (!alert_out_first && !alert_out_second
		&& !sda_out) else $error("open drain pin driven high");
	fault_off_a: assert property (fault_in |-> ##[1:4] !hs_gate_on)
		else $error("fault left gate on");
	warn_keep_a: assert property ($fell(hs_gate_on) |-> hold_q != 3'h0)
		else $error("gate fell without cause");
	release_together_a: assert property ($rose(alert_out_first_oe_n)
		|| $rose(alert_out_second_oe_n) |->
		alert_out_first_oe_n && alert_out_second_oe_n)
		else $error("alerts released apart");
	clear_release_a: assert property (psel && penable && pready
		&& pwrite && paddr == 8'h00 && pwdata[1] |-> ##[1:4]
		alert_out_first_oe_n && alert_out_second_oe_n)
		else $error("clear kept alert");
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("not one wait state");
	err_ready_a: assert property (pready |-> pslverr ==
		(paddr[1:0] != 2'h0 || paddr > 8'h18))
		else $error("error response wrong");
endmodule // fwal_alert_props

/* tb/fwal_host.sv */
// fwal_host.sv: smbus host issuing alert response reads
// assumes tb resolves the open-drain sda; scl idles high between frames
`timescale 1ns/1ns
`include "fwal_consts.vh"
module fwal_host (
	output reg  scl,
	output reg  sda_h,
	input  wire sda
);
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// bit changes late in scl low so the synced responder has settled
	task bit_x(input b, output r);
		begin
			#30 sda_h = b;
			#20 scl = 1'b1;
			#50 r = sda;
			#30 scl = 1'b0;
			#30;
		end
	endtask
	// rv stands in for a rival responder on the wire, 8'hFF for none
	task ara(input [7:0] rv, output ack, output [7:0] d);
		integer   i;
		reg       r;
		reg [7:0] adr;
		begin
			adr = {`FWAL_ARA_ADDR, 1'b1};
			// every pin change lands between pclk rising edges
			#70 sda_h = 1'b0;
			#80 scl = 1'b0;
			#10;
			for (i = 7; i >= 0; i = i - 1)
				bit_x(adr[i], r);
			bit_x(1'b1, r);
			ack = !r;
			for (i = 7; i >= 0; i = i - 1) begin
				bit_x(rv[i], r);
				d[i] = r;
			end
			bit_x(1'b1, r);
			#30 sda_h = 1'b0;
			#40 scl = 1'b1;
			#80 sda_h = 1'b1;
			#80;
		end
	endtask
endmodule // fwal_host

/* tb/tb.sv */
// tb.sv: self-checking bench for the fault/warning alert block
// assumes fwal_host on the smbus side; props bound below
`timescale 1ns/1ns
module tb;
	reg         pclk, presetn, psel, penable, pwrite, sample_valid;
	reg         uv_event, ov_event, oc_timeout, reg_warn, fet_bad, cml;
	reg         rerr, ack, w2_under;
	reg  [11:0] iout_oc_lim, w2_lim, vin_uv_lim, vout_ov_lim;
	reg  [6:0]  dev_addr;
	reg  [7:0]  paddr, byte_q;
	reg  [31:0] pwdata, rdat;
	reg  [11:0] iout_code, vin_code, vout_code, vin_ov_lim, vout_uv_lim;
	wire [31:0] prdata;
	wire        pready, pslverr, sda_out, sda_oe_n, hs_gate_on, scl, sda_h;
	wire        al1, al1_oe_n, al2, al2_oe_n;
	wire        sda_w = sda_h & (sda_oe_n | sda_out);
	wire [2:0]  pins = {hs_gate_on, al2_oe_n, al1_oe_n};
	integer     n_fail, comparisons, cyc, k;

	fwal_alert dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .uv_event(uv_event),
		.ov_event(ov_event), .oc_timeout(oc_timeout),
		.current_regulation_active_warn(reg_warn), .fet_health_bad(fet_bad),
		.cml_error(cml), .sample_valid(sample_valid), .iout_code(iout_code),
		.vin_code(vin_code), .vout_code(vout_code),
		.iout_oc_limit(iout_oc_lim), .second_current_warn_limit(w2_lim),
		.second_warn_under(w2_under), .vin_uv_limit(vin_uv_lim),
		.vin_ov_limit(vin_ov_lim), .vout_uv_limit(vout_uv_lim),
		.vout_ov_limit(vout_ov_lim), .dev_addr(dev_addr), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.hs_gate_on(hs_gate_on), .alert_out_first(al1),
		.alert_out_first_oe_n(al1_oe_n), .alert_out_second(al2),
		.alert_out_second_oe_n(al2_oe_n)
	);
	fwal_host host (.scl(scl), .sda_h(sda_h), .sda(sda_w));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_fail = n_fail + 1;
			test_done;
		end
	end
	task test_done;
		begin
			$display("comparisons %0d n_fail %0d", comparisons, n_fail);
			if (n_fail == 0 && comparisons > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] s);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				n_fail = n_fail + 1;
				$display("unexpected %s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task wait_n(input integer n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			rdat = prdata;
			rerr = pslverr;
			{psel, penable} <= 2'h0;
			@(posedge pclk);
		end
	endtask
	task rd_chk(input string nm, input [7:0] a, input [31:0] e);
		begin
			apb(1'b0, a, 32'h0);
			chk(nm, e, rdat);
		end
	endtask
	task smp(input [11:0] vi, input [11:0] vo);
		begin
			{vin_code, vout_code, iout_code} <= {vi, vo, 12'h7FF};
			sample_valid <= 1'b1;
			@(posedge pclk);
			sample_valid <= 1'b0;
			wait_n(6);
		end
	endtask

	initial begin
		{n_fail, comparisons, cyc} = 96'h0;
		{presetn, psel, penable, pwrite, sample_valid, paddr, pwdata} = 45'h0;
		{uv_event, ov_event, oc_timeout, reg_warn, fet_bad, cml} = 6'h00;
		{iout_code, vin_code, vout_code} = 36'h0;
		{vin_ov_lim, vout_uv_lim, dev_addr} = {12'h800, 12'h100, 7'h2A};
		{iout_oc_lim, w2_lim, w2_under, vin_uv_lim, vout_ov_lim} =
			{12'hFFF, 12'hFFF, 1'b0, 12'h000, 12'hFFF};
		wait_n(10);
		presetn <= 1'b1;
		wait_n(2);
		chk("pins", 3'h7, pins);
		rd_chk("ctrl", 8'h00, 32'h1);
		rd_chk("mask first", 8'h08, 32'h0);
		rd_chk("mask second", 8'h0C, 32'h8000);
		rd_chk("mode", 8'h10, 32'h0);
		rd_chk("state", 8'h14, 32'h4);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped", 32'h1, rerr);
		{fet_bad, reg_warn} <= 2'h3;
		wait_n(8);
		chk("pins", 3'h5, pins);
		{fet_bad, reg_warn} <= 2'h0;
		wait_n(8);
		rd_chk("status", 8'h04, 32'h8010);
		apb(1'b1, 8'h00, 32'h3);
		wait_n(4);
		chk("pins", 3'h7, pins);
		rd_chk("status", 8'h04, 32'h0);
		{iout_oc_lim, w2_lim, vin_uv_lim, vout_ov_lim} <=
			{12'h7FE, 12'h7FE, 12'h900, 12'h0FF};
		smp(12'h800, 12'h100);
		rd_chk("status", 8'h04, 32'h4E0);
		chk("pins", 3'h7, pins);
		apb(1'b1, 8'h00, 32'h3);
		// equal limits must not warn; warn2 in its under-limit sense
		{iout_oc_lim, w2_lim, w2_under, vin_uv_lim, vout_ov_lim} <=
			{12'h7FF, 12'h800, 1'b1, 12'h800, 12'h100};
		smp(12'h800, 12'h100);
		rd_chk("status", 8'h04, 32'h40);
		{iout_oc_lim, w2_lim, w2_under, vin_uv_lim, vout_ov_lim} <=
			{12'hFFF, 12'hFFF, 1'b0, 12'h000, 12'hFFF};
		apb(1'b1, 8'h00, 32'h3);
		rd_chk("status", 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'hFFFF);
		for (k = 0; k < 3; k = k + 1) begin
			{oc_timeout, ov_event, uv_event} <= 3'h1 << k;
			wait_n(8);
			chk("pins", 3'h2, pins);
			apb(1'b1, 8'h00, 32'h3);
			wait_n(4);
			chk("pins", 3'h3, pins);
			rd_chk("status", 8'h04, 32'h1 << k);
			{oc_timeout, ov_event, uv_event} <= 3'h0;
			wait_n(8);
			rd_chk("status", 8'h04, 32'h1 << k);
			apb(1'b1, 8'h00, 32'h0);
			apb(1'b1, 8'h00, 32'h1);
			wait_n(4);
			rd_chk("status", 8'h04, 32'h0);
			chk("pins", 3'h7, pins);
		end
		smp(12'h800, 12'h100);
		rd_chk("status", 8'h04, 32'h0);
		smp(12'h801, 12'h0FF);
		chk("pins", 3'h6, pins);
		rd_chk("status", 8'h04, 32'h300);
		rd_chk("sample", 8'h18, 32'h080117FF);
		apb(1'b1, 8'h00, 32'h3);
		wait_n(4);
		chk("pins", 3'h7, pins);
		smp(12'h801, 12'h0FF);
		chk("pins", 3'h6, pins);
		host.ara(8'h00, ack, byte_q);
		wait_n(2);
		chk("ara lost", 32'h100, {ack, byte_q});
		chk("pins", 3'h6, pins);
		host.ara(8'hFF, ack, byte_q);
		wait_n(2);
		chk("ara addr", 32'hAA, {ack, byte_q[7:1]});
		chk("pins", 3'h7, pins);
		rd_chk("status", 8'h04, 32'h300);
		smp(12'h801, 12'h0FF);
		chk("pins", 3'h7, pins);
		cml <= 1'b1;
		@(posedge pclk);
		cml <= 1'b0;
		wait_n(6);
		chk("pins", 3'h6, pins);
		apb(1'b1, 8'h00, 32'h3);
		host.ara(8'hFF, ack, byte_q);
		wait_n(2);
		chk("ara idle", 32'h0, ack);
		apb(1'b1, 8'h10, 32'h1);
		wait_n(4);
		chk("pins", 3'h6, pins);
		apb(1'b1, 8'h10, 32'h4);
		uv_event <= 1'b1;
		wait_n(8);
		chk("pins", 3'h3, pins);
		apb(1'b1, 8'h10, 32'h14);
		wait_n(4);
		chk("pins", 3'h2, pins);
		test_done;
	end
endmodule // tb

bind fwal_alert fwal_alert_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .uv_event(uv_event), .ov_event(ov_event),
	.oc_timeout(oc_timeout), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.hs_gate_on(hs_gate_on), .alert_out_first(alert_out_first),
	.alert_out_first_oe_n(alert_out_first_oe_n),
	.alert_out_second(alert_out_second),
	.alert_out_second_oe_n(alert_out_second_oe_n)
);
